//--- logic/gfx_flags_bank.sv
// Word-addressed system register bank with the two flag words, user memory and machine stack
// Behaviour
// - User registers are read and written, except the user SP at 0x080, which is read only
// - Stack: 128 words at 0x180, grows upward
// - User memory holds 255 words
// - Flag0 bit1: 0 solid, 1 outline
// - Flag0 bit2 opaque text, bit3 outlines
// - Flag0 bits4-7 text styles, self clearing
// - Flag0 bit8 enables clipping
// - Flag0 bit14: 0 16-bit, 1 8-bit colour
// - Flag0 bit15: built-in or stored font
// - Flag1 bit0 storage present, bit1 type
// - Flag1 bits2,3 read/write in progress
// - Flag1 bit8 executing from storage
// - Flag1 bit10 virtual processor running
// - Flag1 bit11 arms debug breakpoint
// - Flag1 bit12 buffered comms active
// - Flag1 bit14 wide bus, bit13 pad
// - Flag1 bit15 font is variable width
// - Word access by word index primitives
`include "gfx_flags_defines.svh"
module gfx_flags_bank
(
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // Software word access port
   input wire logic RD_I,
   input wire logic WR_I,
   input wire gfx_flags_pkg::waddr_t ADDR_I,
   input wire gfx_flags_pkg::word_t WDATA_I,
   output gfx_flags_pkg::word_t RDATA_O,
   output logic RVALID_O,
   // Stack push and pop from the virtual machine
   input wire logic PUSH_I,
   input wire logic POP_I,
   input wire gfx_flags_pkg::word_t PUSH_DATA_I,
   output gfx_flags_pkg::word_t STACK_PTR_O,
   // System function updates of flag bits
   input wire logic SYS_WE0_I,
   input wire gfx_flags_pkg::word_t SYS_MASK0_I,
   input wire gfx_flags_pkg::word_t SYS_DATA0_I,
   input wire logic TEXT_DONE_I,
   input wire logic STORAGE_PRESENT_I,
   input wire logic STORAGE_TYPE_I,
   input wire logic STORAGE_READ_I,
   input wire logic STORAGE_WRITE_I,
   input wire logic EXEC_FROM_STORAGE_I,
   input wire logic VM_RUNNING_I,
   input wire logic COMMS_ACTIVE_I,
   input wire logic PAD_TRANSFER_I,
   input wire logic WIDE_BUS_I,
   input wire logic VAR_WIDTH_I,
   input wire logic SYS_WE1_I,
   input wire gfx_flags_pkg::word_t SYS_MASK1_I,
   input wire gfx_flags_pkg::word_t SYS_DATA1_I,
   // Decoded controls
   output logic FILL_OUTLINE_O,
   output logic TEXT_OPAQUE_O,
   output logic SHAPE_OUTLINE_O,
   output logic [3:0] TEXT_STYLE_O,
   output logic CLIP_EN_O,
   output logic COLOUR_8BIT_O,
   output logic FONT_FROM_STORAGE_O,
   output logic ONEWIRE_PIN_SEL_O,
   output logic DEBUG_BREAK_ARM_O,
   output gfx_flags_pkg::word_t FLAGS0_O,
   output gfx_flags_pkg::word_t FLAGS1_O
);
   import gfx_flags_pkg::*;

   word_t flags0;
   word_t flags1;
   word_t next_flags0;
   word_t next_flags1;
   logic [7:0] sp;
   acc_state_t state;
   logic [1:0] rsel;
   word_t mem_rdata;
   word_t stk_rdata;
   logic mem_we;
   logic stk_we;
   logic [7:0] mem_waddr;
   logic [7:0] mem_raddr;
   logic [6:0] stk_waddr;
   logic [6:0] stk_raddr;
   logic stk_hit;
   logic mem_hit;
   logic do_push;
   word_t status_in;
   logic [7:0] next_sp_view;

   // Region decode of the word index
   assign mem_hit = (ADDR_I >= `ADDR_USR_MEM_BASE) && (ADDR_I < `ADDR_STACK_BASE);
   assign stk_hit = ADDR_I >= `ADDR_STACK_BASE;
   assign mem_waddr = 8'(ADDR_I - `ADDR_USR_MEM_BASE);
   assign mem_raddr = mem_waddr;
   assign do_push = PUSH_I && (sp < 8'(`STACK_DEPTH));
   assign stk_we = do_push || (WR_I && stk_hit);
   assign stk_waddr = do_push ? sp[6:0] : 7'(ADDR_I - `ADDR_STACK_BASE);
   assign stk_raddr = 7'(ADDR_I - `ADDR_STACK_BASE);
   assign mem_we = WR_I && mem_hit && !do_push;

   // Status bits fed straight from system functions
   always_comb
   begin
      status_in = 16'h0000;
      status_in[`F1_STORAGE_PRESENT] = STORAGE_PRESENT_I;
      status_in[`F1_STORAGE_TYPE] = STORAGE_TYPE_I;
      status_in[`F1_STORAGE_READ] = STORAGE_READ_I;
      status_in[`F1_STORAGE_WRITE] = STORAGE_WRITE_I;
      status_in[`F1_EXEC_STORAGE] = EXEC_FROM_STORAGE_I;
      status_in[`F1_VM_RUNNING] = VM_RUNNING_I;
      status_in[`F1_COMMS_ACTIVE] = COMMS_ACTIVE_I;
      status_in[`F1_PAD_TRANSFER] = PAD_TRANSFER_I;
      status_in[`F1_WIDE_BUS] = WIDE_BUS_I;
      status_in[`F1_VAR_WIDTH] = VAR_WIDTH_I;
   end

   // Next flag word values; software reaches only the user mask bits
   always_comb
   begin
      next_flags0 = flags0;
      if (TEXT_DONE_I)
      begin
         next_flags0[`F0_UNDERLINE:`F0_BOLD] = 4'h0;
      end
      if (SYS_WE0_I)
      begin
         next_flags0 = (next_flags0 & ~SYS_MASK0_I) | (SYS_DATA0_I & SYS_MASK0_I);
      end
      if (WR_I && (ADDR_I == `ADDR_FLAGS_WORD0))
      begin
         next_flags0 = (next_flags0 & ~`F0_USER_MASK) | (WDATA_I & `F0_USER_MASK);
      end
      next_flags1 = flags1;
      if (SYS_WE1_I)
      begin
         next_flags1 = (next_flags1 & ~SYS_MASK1_I) | (SYS_DATA1_I & SYS_MASK1_I);
      end
      if (WR_I && (ADDR_I == `ADDR_FLAGS_WORD1))
      begin
         next_flags1 = (next_flags1 & ~`F1_USER_MASK) | (WDATA_I & `F1_USER_MASK);
      end
      next_flags1 = (next_flags1 & ~`F1_STATUS_MASK_C) | status_in;
   end

   // Flag word storage
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         flags0 <= `FLAGS_RESET;
         flags1 <= `FLAGS_RESET;
      end
      else
      begin
         flags0 <= next_flags0;
         flags1 <= next_flags1;
      end
   end

   // Stack pointer, upward growth
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         sp <= 8'h00;
      end
      else if (do_push)
      begin
         sp <= sp + 8'h01;
      end
      else if (POP_I && (sp != 8'h00))
      begin
         sp <= sp - 8'h01;
      end
   end

   // Read access sequencing
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         state <= ST_IDLE;
         rsel <= 2'h0;
         RDATA_O <= 16'h0000;
         RVALID_O <= 1'b0;
      end
      else
      begin
         RVALID_O <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (RD_I)
               begin
                  state <= ST_READ;
                  rsel <= stk_hit ? 2'h2 : (mem_hit ? 2'h1 : 2'h0);
                  case (ADDR_I)
                     `ADDR_FLAGS_WORD0: RDATA_O <= flags0;
                     `ADDR_FLAGS_WORD1: RDATA_O <= flags1;
                     `ADDR_USR_SP: RDATA_O <= {8'h00, sp};
                     default: RDATA_O <= 16'h0000;
                  endcase
               end
            end
            ST_READ:
            begin
               if (rsel == 2'h1)
               begin
                  RDATA_O <= mem_rdata;
               end
               else if (rsel == 2'h2)
               begin
                  RDATA_O <= stk_rdata;
               end
               RVALID_O <= 1'b1;
               state <= ST_IDLE;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Decoded control outputs, registered
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         FILL_OUTLINE_O <= 1'b0;
         TEXT_OPAQUE_O <= 1'b0;
         SHAPE_OUTLINE_O <= 1'b0;
         TEXT_STYLE_O <= 4'h0;
         CLIP_EN_O <= 1'b0;
         COLOUR_8BIT_O <= 1'b0;
         FONT_FROM_STORAGE_O <= 1'b0;
         ONEWIRE_PIN_SEL_O <= 1'b0;
         DEBUG_BREAK_ARM_O <= 1'b0;
         FLAGS0_O <= 16'h0000;
         FLAGS1_O <= 16'h0000;
         STACK_PTR_O <= 16'h0000;
      end
      else
      begin
         FILL_OUTLINE_O <= next_flags0[`F0_FILL_STYLE];
         TEXT_OPAQUE_O <= next_flags0[`F0_TEXT_OPAQUE];
         SHAPE_OUTLINE_O <= next_flags0[`F0_OUTLINE_EN];
         TEXT_STYLE_O <= next_flags0[`F0_UNDERLINE:`F0_BOLD];
         CLIP_EN_O <= next_flags0[`F0_CLIP_EN];
         COLOUR_8BIT_O <= next_flags0[`F0_COLOUR_DEPTH];
         FONT_FROM_STORAGE_O <= next_flags0[`F0_FONT_SOURCE];
         ONEWIRE_PIN_SEL_O <= next_flags1[`F1_ONEWIRE_PIN];
         DEBUG_BREAK_ARM_O <= next_flags1[`F1_DEBUG_BREAK];
         FLAGS0_O <= next_flags0;
         FLAGS1_O <= next_flags1;
         STACK_PTR_O <= 16'(`ADDR_STACK_BASE) + {8'h00, next_sp_view};
      end
   end
   // Stack pointer value after this edge, shown as a word address
   assign next_sp_view = do_push ? sp + 8'h01 : ((POP_I && (sp != 8'h00)) ? sp - 8'h01 : sp);

   // User memory array
   word_store #(.DEPTH(`USR_MEM_DEPTH), .AW(8)) u_usr_mem
   (
      .clk_i(CLK_I),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(WDATA_I),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   // Machine stack array
   word_store #(.DEPTH(`STACK_DEPTH), .AW(7)) u_stack
   (
      .clk_i(CLK_I),
      .we_i(stk_we),
      .waddr_i(stk_waddr),
      .wdata_i(do_push ? PUSH_DATA_I : WDATA_I),
      .raddr_i(stk_raddr),
      .rdata_o(stk_rdata)
   );

   // Assertions
   a_style_autoclear: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (TEXT_DONE_I && !SYS_WE0_I && !WR_I) |=> (flags0[7:4] == 4'h0))
      else $error("text style bits not cleared");
   a_push_advance: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (PUSH_I && !POP_I && sp < 8'd128) |=> (sp == $past(sp) + 8'h01))
      else $error("stack pointer did not advance");
   a_stack_limit: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      sp <= 8'd128)
      else $error("stack pointer beyond depth");
   a_status_follow: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      VM_RUNNING_I |=> flags1[10])
      else $error("running flag not reflected");
   a_internal_kept: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (WR_I && ADDR_I == 9'h07e && !SYS_WE0_I) |=> (flags0[0] == $past(flags0[0])))
      else $error("internal bit changed by software");
   a_user_write: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (WR_I && ADDR_I == 9'h07e && !SYS_WE0_I) |=> (flags0[8] == $past(WDATA_I[8])))
      else $error("clip bit not written");
   a_read_latency: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (RD_I && state == ST_IDLE) |-> ##2 RVALID_O)
      else $error("read answer late");
   a_pin_select: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (WR_I && ADDR_I == 9'h07f) |=> (ONEWIRE_PIN_SEL_O == $past(WDATA_I[4])))
      else $error("one-wire pin select not taken from software write");
   c_push: cover property (@(posedge CLK_I) disable iff (!RST_B_I) PUSH_I ##1 POP_I);
   c_read: cover property (@(posedge CLK_I) disable iff (!RST_B_I) RD_I ##2 RVALID_O);
   c_clear: cover property (@(posedge CLK_I) disable iff (!RST_B_I) (flags0[4] ##1 !flags0[4]));
endmodule

//--- logic/gfx_flags_defines.svh
// Offsets, field positions, sizes and reset values of the graphics flag register bank
`ifndef GFX_FLAGS_DEFINES_SVH
`define GFX_FLAGS_DEFINES_SVH
`define ADDR_FLAGS_WORD0 9'h07e
`define ADDR_FLAGS_WORD1 9'h07f
`define ADDR_USR_SP 9'h080
`define ADDR_USR_MEM_BASE 9'h081
`define USR_MEM_DEPTH 255
`define ADDR_STACK_BASE 9'h180
`define STACK_DEPTH 128
`define F0_STREAM_LOCK 0
`define F0_FILL_STYLE 1
`define F0_TEXT_OPAQUE 2
`define F0_OUTLINE_EN 3
`define F0_BOLD 4
`define F0_ITALIC 5
`define F0_INVERSE 6
`define F0_UNDERLINE 7
`define F0_CLIP_EN 8
`define F0_COLOUR_DEPTH 14
`define F0_FONT_SOURCE 15
`define F1_STORAGE_PRESENT 0
`define F1_STORAGE_TYPE 1
`define F1_STORAGE_READ 2
`define F1_STORAGE_WRITE 3
`define F1_ONEWIRE_PIN 4
`define F1_EXEC_STORAGE 8
`define F1_VM_RUNNING 10
`define F1_DEBUG_BREAK 11
`define F1_COMMS_ACTIVE 12
`define F1_PAD_TRANSFER 13
`define F1_WIDE_BUS 14
`define F1_VAR_WIDTH 15
`define F0_USER_MASK 16'hc10e
`define F1_USER_MASK 16'h0810
`define FLAGS_RESET 16'h0000
`define F1_STATUS_MASK_C 16'hf50f
`endif

//--- logic/gfx_flags_pkg.sv
// Types shared by the graphics flag register bank
package gfx_flags_pkg;
   typedef logic [15:0] word_t;
   typedef logic [8:0] waddr_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } acc_state_t;
endpackage

//--- logic/word_store.sv
// Word-wide storage array used for user memory and machine stack
module word_store
#(
   parameter int DEPTH = 128,
   parameter int AW = 8
)
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [15:0] rdata_o
);
   logic [15:0] mem [DEPTH];

   // Synchronous write and read
   always_ff @(posedge clk_i)
   begin
      if (we_i && (int'(waddr_i) < DEPTH))
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : 16'h0000;
   end
endmodule

//--- tb/tb_gfx_flags_bank.sv
// Self-checking testbench for the graphics flag register bank
`include "gfx_flags_defines.svh"
module tb_gfx_flags_bank
   import gfx_flags_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_I, RST_B_I, RD_I, WR_I, PUSH_I, POP_I, SYS_WE0_I, SYS_WE1_I, TEXT_DONE_I, RVALID_O;
   logic STORAGE_PRESENT_I, STORAGE_TYPE_I, STORAGE_READ_I, STORAGE_WRITE_I, EXEC_FROM_STORAGE_I;
   logic VM_RUNNING_I, COMMS_ACTIVE_I, PAD_TRANSFER_I, WIDE_BUS_I, VAR_WIDTH_I;
   logic FILL_OUTLINE_O, TEXT_OPAQUE_O, SHAPE_OUTLINE_O, CLIP_EN_O, COLOUR_8BIT_O;
   logic FONT_FROM_STORAGE_O, ONEWIRE_PIN_SEL_O, DEBUG_BREAK_ARM_O;
   logic [3:0] TEXT_STYLE_O;
   logic [9:0] st;
   waddr_t ADDR_I, a;
   word_t WDATA_I, PUSH_DATA_I, SYS_MASK0_I, SYS_DATA0_I, SYS_MASK1_I, SYS_DATA1_I;
   word_t RDATA_O, STACK_PTR_O, FLAGS0_O, FLAGS1_O, f0, f1u, d, r;
   word_t stk [128];
   logic [31:0] seed;
   int failures, num_checks, cyc;

   // Status levels driven as one vector
   assign {VAR_WIDTH_I, WIDE_BUS_I, PAD_TRANSFER_I, COMMS_ACTIVE_I, VM_RUNNING_I, EXEC_FROM_STORAGE_I,
           STORAGE_WRITE_I, STORAGE_READ_I, STORAGE_TYPE_I, STORAGE_PRESENT_I} = st;

   gfx_flags_bank gfx_flags_bank_inst
   (
      .CLK_I, .RST_B_I, .RD_I, .WR_I, .ADDR_I, .WDATA_I, .RDATA_O, .RVALID_O, .PUSH_I, .POP_I,
      .PUSH_DATA_I, .STACK_PTR_O, .SYS_WE0_I, .SYS_MASK0_I, .SYS_DATA0_I, .TEXT_DONE_I,
      .STORAGE_PRESENT_I, .STORAGE_TYPE_I, .STORAGE_READ_I, .STORAGE_WRITE_I, .EXEC_FROM_STORAGE_I,
      .VM_RUNNING_I, .COMMS_ACTIVE_I, .PAD_TRANSFER_I, .WIDE_BUS_I, .VAR_WIDTH_I, .SYS_WE1_I,
      .SYS_MASK1_I, .SYS_DATA1_I, .FILL_OUTLINE_O, .TEXT_OPAQUE_O, .SHAPE_OUTLINE_O, .TEXT_STYLE_O,
      .CLIP_EN_O, .COLOUR_8BIT_O, .FONT_FROM_STORAGE_O, .ONEWIRE_PIN_SEL_O, .DEBUG_BREAK_ARM_O,
      .FLAGS0_O, .FLAGS1_O
   );

   // Pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic word_t rnd();
      seed = lfsr(seed);
      return seed[15:0];
   endfunction

   // Expected status part of flag word 1
   function automatic word_t stat_word(input logic [9:0] s);
      return {s[9:6], 1'b0, s[5], 1'b0, s[4], 4'h0, s[3:0]};
   endfunction

   task chk(input word_t seen, input word_t exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test();
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Software word write: one pulse, effect seen after the taking edge
   task wr(input waddr_t ad, input word_t v);
      @(posedge CLK_I);
      WR_I <= 1'b1;
      ADDR_I <= ad;
      WDATA_I <= v;
      @(posedge CLK_I);
      WR_I <= 1'b0;
      #1;
   endtask

   // Software word read; answer is sampled high just after the first edge after the taking edge
   task rd(input waddr_t ad, output word_t v);
      int n;
      @(posedge CLK_I);
      RD_I <= 1'b1;
      ADDR_I <= ad;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      n = 0;
      do
      begin
         @(posedge CLK_I);
         #1;
         n++;
      end
      while (RVALID_O !== 1'b1 && n < 4);
      chk(word_t'(n + 1), 16'h0002);
      v = RDATA_O;
   endtask

   task rdchk(input waddr_t ad, input word_t e);
      rd(ad, r);
      chk(r, e);
   endtask

   // System masked write to either flag word
   task sysw(input logic w1, input word_t m, input word_t v);
      @(posedge CLK_I);
      SYS_WE0_I <= !w1;
      SYS_WE1_I <= w1;
      SYS_MASK0_I <= m;
      SYS_MASK1_I <= m;
      SYS_DATA0_I <= v;
      SYS_DATA1_I <= v;
      @(posedge CLK_I);
      SYS_WE0_I <= 1'b0;
      SYS_WE1_I <= 1'b0;
      #1;
   endtask

   // Stack push or pop pulse
   task stk_op(input logic push, input word_t v);
      @(posedge CLK_I);
      PUSH_I <= push;
      POP_I <= !push;
      PUSH_DATA_I <= v;
      @(posedge CLK_I);
      PUSH_I <= 1'b0;
      POP_I <= 1'b0;
      #1;
   endtask

   // Clock
   initial
   begin
      CLK_I = 1'b0;
      forever #25 CLK_I = ~CLK_I;
   end

   // Hang guard
   always @(posedge CLK_I)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         failures++;
         stop_test();
      end
   end

   // Main sequence
   initial
   begin
      {RST_B_I, RD_I, WR_I, PUSH_I, POP_I, SYS_WE0_I, SYS_WE1_I, TEXT_DONE_I} = '0;
      {ADDR_I, WDATA_I, PUSH_DATA_I, SYS_MASK0_I, SYS_DATA0_I, SYS_MASK1_I, SYS_DATA1_I} = '0;
      st = '0;
      seed = 32'hdabf4cde;
      f0 = '0;
      f1u = '0;
      repeat (2) @(posedge CLK_I);
      chk(FLAGS0_O, `FLAGS_RESET);
      chk(FLAGS1_O, `FLAGS_RESET);
      RST_B_I <= 1'b1;
      @(posedge CLK_I);
      #1;
      chk(STACK_PTR_O, 16'h0180);
      stk_op(1'b0, 16'h0000);
      chk(STACK_PTR_O, 16'h0180);
      // Random flag traffic from software, system and status levels
      for (int i = 0; i < 24; i++)
      begin
         @(posedge CLK_I);
         d = rnd();
         st <= d[9:0];
         d = rnd();
         wr(`ADDR_FLAGS_WORD0, d);
         f0 = (f0 & ~`F0_USER_MASK) | (d & `F0_USER_MASK);
         chk(FLAGS0_O, f0);
         chk({6'h0, FONT_FROM_STORAGE_O, COLOUR_8BIT_O, CLIP_EN_O, TEXT_STYLE_O, SHAPE_OUTLINE_O, TEXT_OPAQUE_O,
              FILL_OUTLINE_O}, {6'h0, f0[15], f0[14], f0[8], f0[7:1]});
         d = rnd();
         wr(`ADDR_FLAGS_WORD1, d);
         f1u = (f1u & ~`F1_USER_MASK) | (d & `F1_USER_MASK);
         d = rnd();
         r = rnd();
         sysw(i[0], d, r);
         if (i[0])
            f1u = (f1u & ~d) | (r & d);
         else
            f0 = (f0 & ~d) | (r & d);
         chk(FLAGS0_O, f0);
         chk(FLAGS1_O, stat_word(st) | (f1u & 16'h0af0));
         chk({14'h0, ONEWIRE_PIN_SEL_O, DEBUG_BREAK_ARM_O}, {14'h0, f1u[4], f1u[11]});
         rdchk(`ADDR_FLAGS_WORD0, f0);
         rdchk(`ADDR_FLAGS_WORD1, stat_word(st) | (f1u & 16'h0af0));
      end
      // Text styles set by the system and cleared after use
      sysw(1'b0, 16'h00f0, 16'h00f0);
      chk({12'h0, TEXT_STYLE_O}, 16'h000f);
      @(posedge CLK_I);
      TEXT_DONE_I <= 1'b1;
      @(posedge CLK_I);
      TEXT_DONE_I <= 1'b0;
      #1;
      f0 = (f0 | 16'h00f0) & 16'hff0f;
      chk(FLAGS0_O, f0);
      // User memory, boundaries first
      for (int i = 0; i < 10; i++)
      begin
         a = (i == 0) ? 9'h081 : (i == 1) ? 9'h17f : waddr_t'(9'h081 + rnd() % 255);
         d = rnd();
         wr(a, d);
         rdchk(a, d);
      end
      // System-class locations are only ever read by software
      rdchk(9'h07d, 16'h0000);
      // Stack filled past full, then one pop
      for (int i = 0; i < 129; i++)
      begin
         d = rnd();
         if (i < 128)
            stk[i] = d;
         stk_op(1'b1, d);
         chk(STACK_PTR_O, word_t'(16'h0181 + ((i < 128) ? i : 127)));
      end
      rdchk(9'h180, stk[0]);
      rdchk(9'h1ff, stk[127]);
      rdchk(9'h080, 16'h0080);
      stk_op(1'b0, 16'h0000);
      chk(STACK_PTR_O, 16'h01ff);
      stop_test();
   end
endmodule
